// ===== src/rss_consts.svh
// constants for the rotate, subtract, skip and set execution block
// Behaviour
// - Rotate right through carry on memory writes back the byte shifted down, old carry into bit 7, old bit 0 into carry, and changes only carry.
// - The working-register variant puts the rotated byte in the working register, takes carry from memory bit 0 and leaves memory alone.
// - Subtract with borrow adds working register, inverted memory byte and carry, to the working register or to memory, updating overflow, zero, half carry and carry.
// - Subtract adds working register, inverted memory byte and one, to the working register or to memory, updating overflow, zero, half carry and carry.
// - Subtract immediate adds working register, inverted operand and one into the working register, updating overflow, zero, half carry and carry.
// - Decrement and skip writes memory minus one back, skips when the result is zero and touches no flag.
// - The working-register decrement puts memory minus one in the working register, keeps memory, skips on zero and touches no flag.
// - Increment and skip writes memory plus one back, skips when it wraps to zero and touches no flag.
// - The working-register increment puts memory plus one in the working register, keeps memory, skips on zero and touches no flag.
// - Bit test skip skips when the selected memory bit is one and changes neither memory nor flags.
// - A met skip condition discards the prefetched instruction with one dummy cycle, so the instruction takes two cycles.
// - Set byte writes all ones to the memory byte and touches no flag.
// - Set bit forces only the selected memory bit to one and touches no flag.
// - Nibble swap exchanges the two halves of the memory byte in place and touches no flag.
`ifndef RSS_CONSTS_SVH
`define RSS_CONSTS_SVH
`define RSS_DATA_W       8
`define RSS_MSB          7
`define RSS_NIB_HI       7
`define RSS_NIB_SPLIT    4
`define RSS_NIB_LO       3
`define RSS_ALL_ONES     8'hFF
`define RSS_ONE          8'h01
`define RSS_WREG_RST     8'h00
`define RSS_FLAG_RST     1'h0
`define RSS_DUMMY_CYCLES 1
`endif

// ===== src/rss_pkg.sv
// types shared by the execution block
package rss_pkg;
	typedef enum logic [4:0] {
		OP_NOP,
		OP_LOAD_WREG,
		OP_ROTATE_RIGHT_THRU_CARRY,
		OP_ROTATE_RIGHT_THRU_CARRY_TO_WREG,
		OP_SUBTRACT_WITH_BORROW,
		OP_SUBTRACT_WITH_BORROW_TO_MEM,
		OP_SUBTRACT,
		OP_SUBTRACT_TO_MEM,
		OP_SUBTRACT_IMM,
		OP_DECREMENT_SKIP_ZERO,
		OP_DECREMENT_SKIP_ZERO_TO_WREG,
		OP_INCREMENT_SKIP_ZERO,
		OP_INCREMENT_SKIP_ZERO_TO_WREG,
		OP_BIT_SET_SKIP,
		OP_SET_BYTE,
		OP_SET_BIT,
		OP_NIBBLE_SWAP
	} rss_op_e;

	typedef enum logic {
		ST_EXEC,
		ST_DUMMY
	} rss_state_e;

	typedef struct packed {
		logic       ovf;
		logic       half;
		logic       carry;
		logic [7:0] sum;
	} rss_sum_s;
endpackage : rss_pkg

// ===== src/rss_alu.sv
// combinational operation decode and arithmetic for the execution block
`include "rss_consts.svh"
module rss_alu (
	input  rss_pkg::rss_op_e i_op,
	input  logic [7:0]       i_working_register,
	input  logic [7:0]       i_mem_data,
	input  logic [7:0]       i_imm,
	input  logic [2:0]       i_bit_sel,
	input  logic             i_carry,
	output logic [7:0]       o_result,
	output logic             o_wr_wreg,
	output logic             o_wr_mem,
	output logic             o_upd_carry,
	output logic             o_upd_arith,
	output logic             o_carry,
	output logic             o_half,
	output logic             o_ovf,
	output logic             o_zero,
	output logic             o_skip
);
	import rss_pkg::*;

	function automatic rss_sum_s add8(input logic [7:0] a, input logic [7:0] b, input logic cin);
		logic [4:0] lo;
		logic [8:0] full;
		rss_sum_s   r;
		lo      = {1'h0, a[3:0]} + {1'h0, b[3:0]} + {4'h0, cin};
		full    = {1'h0, a} + {1'h0, b} + {8'h00, cin};
		r.sum   = full[7:0];
		r.carry = full[8];
		r.half  = lo[4];
		r.ovf   = (a[7] == b[7]) && (full[7] != a[7]);
		return r;
	endfunction : add8

	wire       is_borrow_op = (i_op == OP_SUBTRACT_WITH_BORROW) ||
	                          (i_op == OP_SUBTRACT_WITH_BORROW_TO_MEM);
	wire [7:0] sub_operand  = (i_op == OP_SUBTRACT_IMM) ? ~i_imm : ~i_mem_data;
	wire rss_sum_s borrow_res = add8(i_working_register, sub_operand, i_carry);
	wire rss_sum_s plain_res  = add8(i_working_register, sub_operand, 1'h1);
	wire rss_sum_s sub_res    = is_borrow_op ? borrow_res : plain_res;
	wire [7:0] dec_val      = i_mem_data - `RSS_ONE;
	wire [7:0] inc_val      = i_mem_data + `RSS_ONE;
	wire [7:0] bit_mask     = `RSS_ONE << i_bit_sel;
	wire [7:0] rot_val      = {i_carry, i_mem_data[`RSS_MSB:1]};
	wire [7:0] swap_val     = {i_mem_data[`RSS_NIB_LO:0], i_mem_data[`RSS_NIB_HI:`RSS_NIB_SPLIT]};

	assign o_carry = o_upd_arith ? sub_res.carry : i_mem_data[0];
	assign o_half  = sub_res.half;
	assign o_ovf   = sub_res.ovf;
	assign o_zero  = (sub_res.sum == 8'h00);

	always_comb
	begin
		o_result    = 8'h00;
		o_wr_wreg   = 1'h0;
		o_wr_mem    = 1'h0;
		o_upd_carry = 1'h0;
		o_upd_arith = 1'h0;
		o_skip      = 1'h0;
		case (i_op)
			OP_LOAD_WREG:
			begin
				o_result  = i_imm;
				o_wr_wreg = 1'h1;
			end
			OP_ROTATE_RIGHT_THRU_CARRY:
			begin
				o_result    = rot_val;
				o_wr_mem    = 1'h1;
				o_upd_carry = 1'h1;
			end
			OP_ROTATE_RIGHT_THRU_CARRY_TO_WREG:
			begin
				o_result    = rot_val;
				o_wr_wreg   = 1'h1;
				o_upd_carry = 1'h1;
			end
			OP_SUBTRACT_WITH_BORROW, OP_SUBTRACT, OP_SUBTRACT_IMM:
			begin
				o_result    = sub_res.sum;
				o_wr_wreg   = 1'h1;
				o_upd_arith = 1'h1;
			end
			OP_SUBTRACT_WITH_BORROW_TO_MEM, OP_SUBTRACT_TO_MEM:
			begin
				o_result    = sub_res.sum;
				o_wr_mem    = 1'h1;
				o_upd_arith = 1'h1;
			end
			OP_DECREMENT_SKIP_ZERO:
			begin
				o_result = dec_val;
				o_wr_mem = 1'h1;
				o_skip   = (dec_val == 8'h00);
			end
			OP_DECREMENT_SKIP_ZERO_TO_WREG:
			begin
				o_result  = dec_val;
				o_wr_wreg = 1'h1;
				o_skip    = (dec_val == 8'h00);
			end
			OP_INCREMENT_SKIP_ZERO:
			begin
				o_result = inc_val;
				o_wr_mem = 1'h1;
				o_skip   = (inc_val == 8'h00);
			end
			OP_INCREMENT_SKIP_ZERO_TO_WREG:
			begin
				o_result  = inc_val;
				o_wr_wreg = 1'h1;
				o_skip    = (inc_val == 8'h00);
			end
			OP_BIT_SET_SKIP:
				o_skip = |(i_mem_data & bit_mask);
			OP_SET_BYTE:
			begin
				o_result = `RSS_ALL_ONES;
				o_wr_mem = 1'h1;
			end
			OP_SET_BIT:
			begin
				o_result = i_mem_data | bit_mask;
				o_wr_mem = 1'h1;
			end
			OP_NIBBLE_SWAP:
			begin
				o_result = swap_val;
				o_wr_mem = 1'h1;
			end
			default:
				o_result = 8'h00;
		endcase
	end
endmodule : rss_alu

// ===== src/rss_exec.sv
// execution stage: working register, status flags, memory write-back and skip
`include "rss_consts.svh"
module rss_exec (
	input  logic             i_sys_clk,
	input  logic             i_resetn,
	input  logic             i_op_valid,
	input  rss_pkg::rss_op_e i_op,
	input  logic [7:0]       i_mem_data,
	input  logic [7:0]       i_imm,
	input  logic [2:0]       i_bit_sel,
	input  logic             i_flag_wr,
	input  logic [3:0]       i_flag_wdata,
	output logic             o_ready,
	output logic             o_skip_cycle,
	output logic             o_mem_wr,
	output logic [7:0]       o_mem_wdata,
	output logic [7:0]       o_working_register,
	output logic             o_carry,
	output logic             o_half_carry_flag,
	output logic             o_zero,
	output logic             o_overflow_flag
);
	import rss_pkg::*;

	rss_state_e state_q;
	rss_state_e state_d;
	logic [7:0] working_reg_q;
	logic [7:0] working_reg_d;
	logic       carry_q;
	logic       carry_d;
	logic       half_q;
	logic       half_d;
	logic       zero_q;
	logic       zero_d;
	logic       ovf_q;
	logic       ovf_d;
	logic       mem_wr_q;
	logic [7:0] mem_wdata_q;
	logic [7:0] mem_wdata_d;

	logic [7:0] alu_result;
	logic       alu_wr_wreg;
	logic       alu_wr_mem;
	logic       alu_upd_carry;
	logic       alu_upd_arith;
	logic       alu_carry;
	logic       alu_half;
	logic       alu_ovf;
	logic       alu_zero;
	logic       alu_skip;

	rss_alu u_alu (
		.i_op               (i_op),
		.i_working_register (working_reg_q),
		.i_mem_data         (i_mem_data),
		.i_imm              (i_imm),
		.i_bit_sel          (i_bit_sel),
		.i_carry            (carry_q),
		.o_result           (alu_result),
		.o_wr_wreg          (alu_wr_wreg),
		.o_wr_mem           (alu_wr_mem),
		.o_upd_carry        (alu_upd_carry),
		.o_upd_arith        (alu_upd_arith),
		.o_carry            (alu_carry),
		.o_half             (alu_half),
		.o_ovf              (alu_ovf),
		.o_zero             (alu_zero),
		.o_skip             (alu_skip)
	);

	// the prefetched word offered during the dummy cycle is dropped, not queued
	wire accept      = i_op_valid && (state_q == ST_EXEC);
	wire take_wreg   = accept && alu_wr_wreg;
	wire take_mem    = accept && alu_wr_mem;
	wire take_arith  = accept && alu_upd_arith;
	wire take_carry  = accept && (alu_upd_arith || alu_upd_carry);
	// software preset loses to an instruction in the same cycle
	wire take_preset = i_flag_wr && !accept;

	assign working_reg_d = take_wreg ? alu_result : working_reg_q;
	assign mem_wdata_d   = take_mem ? alu_result : mem_wdata_q;
	assign carry_d       = take_carry ? alu_carry :
	                       take_preset ? i_flag_wdata[0] : carry_q;
	assign half_d        = take_arith ? alu_half :
	                       take_preset ? i_flag_wdata[1] : half_q;
	assign zero_d        = take_arith ? alu_zero :
	                       take_preset ? i_flag_wdata[2] : zero_q;
	assign ovf_d         = take_arith ? alu_ovf :
	                       take_preset ? i_flag_wdata[3] : ovf_q;
	assign state_d       = (accept && alu_skip) ? ST_DUMMY : ST_EXEC;

	always_ff @(posedge i_sys_clk)
	begin
		if (!i_resetn)
		begin
			state_q       <= ST_EXEC;
			working_reg_q <= `RSS_WREG_RST;
			carry_q       <= `RSS_FLAG_RST;
			half_q        <= `RSS_FLAG_RST;
			zero_q        <= `RSS_FLAG_RST;
			ovf_q         <= `RSS_FLAG_RST;
			mem_wr_q      <= 1'h0;
			mem_wdata_q   <= 8'h00;
		end
		else
		begin
			state_q       <= state_d;
			working_reg_q <= working_reg_d;
			carry_q       <= carry_d;
			half_q        <= half_d;
			zero_q        <= zero_d;
			ovf_q         <= ovf_d;
			mem_wr_q      <= take_mem;
			mem_wdata_q   <= mem_wdata_d;
		end
	end

	assign o_ready            = (state_q == ST_EXEC);
	assign o_skip_cycle       = (state_q == ST_DUMMY);
	assign o_mem_wr           = mem_wr_q;
	assign o_mem_wdata        = mem_wdata_q;
	assign o_working_register = working_reg_q;
	assign o_carry            = carry_q;
	assign o_half_carry_flag  = half_q;
	assign o_zero             = zero_q;
	assign o_overflow_flag    = ovf_q;

	wire [3:0] flags_now = {ovf_q, zero_q, half_q, carry_q};

	default clocking cb @(posedge i_sys_clk); endclocking
	default disable iff (!i_resetn);

	a_rotate_mem_write: assert property (
		accept && i_op == OP_ROTATE_RIGHT_THRU_CARRY |=>
			o_mem_wr && o_mem_wdata == {$past(carry_q), $past(i_mem_data[7:1])} &&
			o_carry == $past(i_mem_data[0]) &&
			flags_now[3:1] == $past(flags_now[3:1]) &&
			o_working_register == $past(working_reg_q))
		else $error("rotate through carry to memory wrong");

	a_rotate_wreg_keep: assert property (
		accept && i_op == OP_ROTATE_RIGHT_THRU_CARRY_TO_WREG |=>
			!o_mem_wr && o_working_register == {$past(carry_q), $past(i_mem_data[7:1])} &&
			o_carry == $past(i_mem_data[0]))
		else $error("rotate through carry to working register wrong");

	a_borrow_sub_value: assert property (
		accept && i_op == OP_SUBTRACT_WITH_BORROW |=>
			o_working_register ==
			8'($past(working_reg_q) + 8'(~$past(i_mem_data)) + {7'h00, $past(carry_q)}) &&
			o_carry == ({1'h0, $past(working_reg_q)} + {1'h0, 8'(~$past(i_mem_data))} +
			            {8'h00, $past(carry_q)} > 9'h0FF))
		else $error("subtract with borrow result or carry wrong");

	a_sub_mem_flags: assert property (
		accept && i_op == OP_SUBTRACT_TO_MEM |=>
			o_mem_wr && o_mem_wdata == 8'($past(working_reg_q) - $past(i_mem_data)) &&
			o_carry == ($past(working_reg_q) >= $past(i_mem_data)) &&
			o_working_register == $past(working_reg_q))
		else $error("subtract to memory wrong");

	a_sub_imm_zero: assert property (
		accept && i_op == OP_SUBTRACT_IMM |=>
			o_working_register == 8'($past(working_reg_q) - $past(i_imm)) &&
			o_zero == ($past(working_reg_q) == $past(i_imm)))
		else $error("subtract immediate wrong");

	a_sub_half_ovf: assert property (
		accept && i_op == OP_SUBTRACT |=>
			o_half_carry_flag == ($past(working_reg_q[3:0]) >= $past(i_mem_data[3:0])) &&
			o_overflow_flag == (($past(working_reg_q[7]) != $past(i_mem_data[7])) &&
			                    (o_working_register[7] != $past(working_reg_q[7]))))
		else $error("subtract half carry or overflow wrong");

	a_dec_skip_two: assert property (
		accept && i_op == OP_DECREMENT_SKIP_ZERO && i_mem_data == `RSS_ONE |=>
			o_mem_wr && o_mem_wdata == 8'h00 && o_skip_cycle && !o_ready &&
			flags_now == $past(flags_now) ##1 o_ready)
		else $error("decrement skip did not take two cycles");

	a_dec_wreg_keep: assert property (
		accept && i_op == OP_DECREMENT_SKIP_ZERO_TO_WREG |=>
			!o_mem_wr && o_working_register == 8'($past(i_mem_data) - `RSS_ONE) &&
			o_skip_cycle == ($past(i_mem_data) == `RSS_ONE))
		else $error("decrement to working register wrong");

	a_inc_wrap_skip: assert property (
		accept && i_op == OP_INCREMENT_SKIP_ZERO |=>
			o_mem_wr && o_mem_wdata == 8'($past(i_mem_data) + `RSS_ONE) &&
			o_skip_cycle == ($past(i_mem_data) == `RSS_ALL_ONES) &&
			flags_now == $past(flags_now))
		else $error("increment skip wrong");

	a_inc_wreg_keep: assert property (
		accept && i_op == OP_INCREMENT_SKIP_ZERO_TO_WREG |=>
			!o_mem_wr && o_working_register == 8'($past(i_mem_data) + `RSS_ONE) &&
			o_skip_cycle == ($past(i_mem_data) == `RSS_ALL_ONES))
		else $error("increment to working register wrong");

	a_bit_test_skip: assert property (
		accept && i_op == OP_BIT_SET_SKIP |=>
			o_skip_cycle == $past(i_mem_data[i_bit_sel]) && !o_mem_wr &&
			flags_now == $past(flags_now))
		else $error("bit test skip wrong");

	a_dummy_one_cycle: assert property (
		o_skip_cycle |=> o_ready && !o_skip_cycle && !o_mem_wr &&
			o_working_register == $past(working_reg_q))
		else $error("dummy cycle longer than one or not inert");

	a_no_skip_ready: assert property (
		accept && !alu_skip |=> o_ready)
		else $error("skip inserted without a met condition");

	a_set_byte_ones: assert property (
		accept && i_op == OP_SET_BYTE |=>
			o_mem_wr && o_mem_wdata == `RSS_ALL_ONES && flags_now == $past(flags_now))
		else $error("set byte wrong");

	a_set_bit_only: assert property (
		accept && i_op == OP_SET_BIT |=>
			o_mem_wr && o_mem_wdata == ($past(i_mem_data) | (`RSS_ONE << $past(i_bit_sel))) &&
			o_mem_wdata[$past(i_bit_sel)])
		else $error("set bit wrong");

	a_swap_nibbles: assert property (
		accept && i_op == OP_NIBBLE_SWAP |=>
			o_mem_wr && o_mem_wdata == {$past(i_mem_data[3:0]), $past(i_mem_data[7:4])} &&
			flags_now == $past(flags_now))
		else $error("nibble swap wrong");

	a_borrow_mem_value: assert property (
		accept && i_op == OP_SUBTRACT_WITH_BORROW_TO_MEM |=>
			o_mem_wr &&
			o_mem_wdata ==
			8'($past(working_reg_q) + 8'(~$past(i_mem_data)) + {7'h00, $past(carry_q)}) &&
			o_working_register == $past(working_reg_q))
		else $error("subtract with borrow to memory wrong");

	a_borrow_half_flag: assert property (
		accept && i_op == OP_SUBTRACT_WITH_BORROW |=>
			o_half_carry_flag == ({1'h0, $past(working_reg_q[3:0])} +
			                      {1'h0, ~$past(i_mem_data[3:0])} +
			                      {4'h0, $past(carry_q)} > 5'h0F))
		else $error("subtract with borrow half carry wrong");

	a_sub_wreg_value: assert property (
		accept && i_op == OP_SUBTRACT |=>
			!o_mem_wr && o_working_register == 8'($past(working_reg_q) - $past(i_mem_data)) &&
			o_carry == ($past(working_reg_q) >= $past(i_mem_data)))
		else $error("subtract to working register wrong");

	a_sub_imm_carry: assert property (
		accept && i_op == OP_SUBTRACT_IMM |=>
			!o_mem_wr && o_carry == ($past(working_reg_q) >= $past(i_imm)))
		else $error("subtract immediate carry wrong");

	// zero follows whichever destination the subtract wrote
	a_sub_zero_dest: assert property (
		accept && i_op inside {OP_SUBTRACT_WITH_BORROW, OP_SUBTRACT_WITH_BORROW_TO_MEM,
		                       OP_SUBTRACT, OP_SUBTRACT_TO_MEM, OP_SUBTRACT_IMM} |=>
			o_zero == ((o_mem_wr ? o_mem_wdata : o_working_register) == 8'h00))
		else $error("zero flag does not match the subtract result");

	a_count_flags_keep: assert property (
		accept && i_op inside {OP_DECREMENT_SKIP_ZERO_TO_WREG, OP_INCREMENT_SKIP_ZERO_TO_WREG,
		                       OP_SET_BIT, OP_LOAD_WREG} |=>
			flags_now == $past(flags_now))
		else $error("flag changed by an op that must keep them");

	a_rotate_wreg_flags: assert property (
		accept && i_op == OP_ROTATE_RIGHT_THRU_CARRY_TO_WREG |=>
			flags_now[3:1] == $past(flags_now[3:1]))
		else $error("rotate to working register touched a flag other than carry");

	a_mem_ops_wreg: assert property (
		accept && i_op inside {OP_DECREMENT_SKIP_ZERO, OP_INCREMENT_SKIP_ZERO, OP_SET_BYTE,
		                       OP_SET_BIT, OP_NIBBLE_SWAP, OP_BIT_SET_SKIP} |=>
			o_working_register == $past(working_reg_q))
		else $error("memory op changed the working register");

	// the dropped prefetch must leave no trace, a preset excepted
	a_dummy_no_trace: assert property (
		o_skip_cycle && !i_flag_wr |=>
			flags_now == $past(flags_now) && o_mem_wdata == $past(o_mem_wdata))
		else $error("dropped instruction left a trace");

	a_skip_has_cause: assert property (
		o_skip_cycle |-> $past(accept) && $past(alu_skip))
		else $error("dummy cycle without a met skip condition");

	a_preset_applied: assert property (
		i_flag_wr && !accept |=> flags_now == $past(i_flag_wdata))
		else $error("flag preset not applied");

	a_load_wreg_imm: assert property (
		accept && i_op == OP_LOAD_WREG |=> !o_mem_wr && o_working_register == $past(i_imm))
		else $error("load working register wrong");

	c_skip_taken:    cover property (accept && alu_skip ##1 o_skip_cycle ##1 o_ready);
	c_sub_borrow:    cover property (accept && i_op == OP_SUBTRACT_WITH_BORROW && !carry_q);
	c_rotate_carry:  cover property (accept && i_op == OP_ROTATE_RIGHT_THRU_CARRY && carry_q);
	c_dropped_fetch: cover property (o_skip_cycle && i_op_valid);
	c_inc_wrap:      cover property (accept && i_op == OP_INCREMENT_SKIP_ZERO &&
	                                 i_mem_data == `RSS_ALL_ONES);
endmodule : rss_exec

// ===== tb/testbench.sv
// self-checking bench for the execution block against a behavioural model
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	import rss_pkg::*;

	logic        i_sys_clk;
	logic        i_resetn;
	logic        i_op_valid;
	rss_op_e     i_op;
	logic [7:0]  i_mem_data;
	logic [7:0]  i_imm;
	logic [2:0]  i_bit_sel;
	logic        i_flag_wr;
	logic [3:0]  i_flag_wdata;
	logic        o_ready;
	logic        o_skip_cycle;
	logic        o_mem_wr;
	logic [7:0]  o_mem_wdata;
	logic [7:0]  o_working_register;
	logic        o_carry;
	logic        o_half_carry_flag;
	logic        o_zero;
	logic        o_overflow_flag;
	int          error_cnt;
	int          n_tests;
	int          cyc;
	// model state: working register, flags, last write data
	int          w;
	int          fc;
	int          fh;
	int          fz;
	int          fv;
	int          wd;
	int          mtab [4];

	rss_exec uut (
		.i_sys_clk          (i_sys_clk),
		.i_resetn           (i_resetn),
		.i_op_valid         (i_op_valid),
		.i_op               (i_op),
		.i_mem_data         (i_mem_data),
		.i_imm              (i_imm),
		.i_bit_sel          (i_bit_sel),
		.i_flag_wr          (i_flag_wr),
		.i_flag_wdata       (i_flag_wdata),
		.o_ready            (o_ready),
		.o_skip_cycle       (o_skip_cycle),
		.o_mem_wr           (o_mem_wr),
		.o_mem_wdata        (o_mem_wdata),
		.o_working_register (o_working_register),
		.o_carry            (o_carry),
		.o_half_carry_flag  (o_half_carry_flag),
		.o_zero             (o_zero),
		.o_overflow_flag    (o_overflow_flag)
	);

	initial
	begin
		i_sys_clk = 1'b0;
		forever #5 i_sys_clk = ~i_sys_clk;
	end

	task automatic final_report();
		$display("checks %0d, mismatches %0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : final_report

	task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
		n_tests++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask : chk

	// all results are looked at 1 ns after the taking edge
	task automatic check_all(input int wr, input int sk);
		chk({7'h00, o_mem_wr}, 8'(wr), "write strobe");
		chk(o_mem_wdata, 8'(wd), "write data");
		chk(o_working_register, 8'(w), "working register");
		chk({4'h0, o_overflow_flag, o_zero, o_half_carry_flag, o_carry},
		    8'(fv * 8 + fz * 4 + fh * 2 + fc), "flags");
		chk({6'h00, o_skip_cycle, o_ready}, 8'(sk ? 2 : 1), "skip state");
	endtask : check_all

	task automatic issue(input rss_op_e op, input int m, input int imm, input int bs, input logic fw);
		int r;
		int b;
		int s;
		int cin;
		int wr;
		int sk;
		i_op_valid = 1'b1;
		i_op = op;
		i_mem_data = 8'(m);
		i_imm = 8'(imm);
		i_bit_sel = 3'(bs);
		// a preset offered with an accepted instruction must be ignored
		i_flag_wr = fw;
		i_flag_wdata = 4'($urandom);
		wr = 0;
		sk = 0;
		cin = 1;
		b = 255 - m;
		case (op)
			OP_LOAD_WREG: w = imm;
			OP_ROTATE_RIGHT_THRU_CARRY, OP_ROTATE_RIGHT_THRU_CARRY_TO_WREG:
			begin
				r = fc * 128 + (m >> 1);
				fc = m & 1;
				if (op == OP_ROTATE_RIGHT_THRU_CARRY)
				begin
					wd = r;
					wr = 1;
				end
				else
					w = r;
			end
			OP_SUBTRACT_WITH_BORROW, OP_SUBTRACT_WITH_BORROW_TO_MEM, OP_SUBTRACT,
			OP_SUBTRACT_TO_MEM, OP_SUBTRACT_IMM:
			begin
				if (op inside {OP_SUBTRACT_WITH_BORROW, OP_SUBTRACT_WITH_BORROW_TO_MEM})
					cin = fc;
				if (op == OP_SUBTRACT_IMM)
					b = 255 - imm;
				s = w + b + cin;
				r = s & 255;
				fc = s >> 8;
				fh = ((w & 15) + (b & 15) + cin) >> 4;
				fz = (r == 0);
				fv = (((w ^ r) & (b ^ r) & 128) != 0);
				if (op inside {OP_SUBTRACT_WITH_BORROW_TO_MEM, OP_SUBTRACT_TO_MEM})
				begin
					wd = r;
					wr = 1;
				end
				else
					w = r;
			end
			OP_DECREMENT_SKIP_ZERO, OP_DECREMENT_SKIP_ZERO_TO_WREG, OP_INCREMENT_SKIP_ZERO,
			OP_INCREMENT_SKIP_ZERO_TO_WREG:
			begin
				s = (op inside {OP_DECREMENT_SKIP_ZERO, OP_DECREMENT_SKIP_ZERO_TO_WREG}) ? 255 : 1;
				r = (m + s) & 255;
				sk = (r == 0);
				if (op inside {OP_DECREMENT_SKIP_ZERO, OP_INCREMENT_SKIP_ZERO})
				begin
					wd = r;
					wr = 1;
				end
				else
					w = r;
			end
			OP_BIT_SET_SKIP: sk = (m >> bs) & 1;
			OP_SET_BYTE:
			begin
				wd = 255;
				wr = 1;
			end
			OP_SET_BIT:
			begin
				wd = m | (1 << bs);
				wr = 1;
			end
			OP_NIBBLE_SWAP:
			begin
				wd = ((m & 15) << 4) | (m >> 4);
				wr = 1;
			end
			default: ;
		endcase
		@(posedge i_sys_clk);
		#1;
		check_all(wr, sk);
		if (sk)
		begin
			// offer a writing op in the dummy cycle: it must vanish
			i_op = OP_SET_BYTE;
			i_flag_wr = 1'b0;
			i_mem_data = 8'($urandom);
			@(posedge i_sys_clk);
			#1;
			check_all(0, 0);
		end
	endtask : issue

	task automatic preset(input int v);
		i_op_valid = 1'b0;
		i_flag_wr = 1'b1;
		i_flag_wdata = 4'(v);
		@(posedge i_sys_clk);
		#1;
		fv = (v >> 3) & 1;
		fz = (v >> 2) & 1;
		fh = (v >> 1) & 1;
		fc = v & 1;
		check_all(0, 0);
	endtask : preset

	task automatic do_reset();
		i_resetn = 1'b0;
		i_op_valid = 1'b0;
		i_flag_wr = 1'b0;
		repeat (5) @(posedge i_sys_clk);
		#1;
		i_resetn = 1'b1;
		w = 0;
		fc = 0;
		fh = 0;
		fz = 0;
		fv = 0;
		wd = 0;
		check_all(0, 0);
	endtask : do_reset

	always @(posedge i_sys_clk)
	begin
		cyc++;
		if (cyc == 5000)
		begin
			error_cnt++;
			$display("Error at %0t: run did not finish in time", $time);
			final_report();
		end
	end

	initial
	begin
		// reset, valid and preset strobe are first set by do_reset
		i_op = OP_NOP;
		i_mem_data = 8'h00;
		i_imm = 8'h00;
		i_bit_sel = 3'h0;
		i_flag_wdata = 4'h0;
		void'($urandom(32'h928c_4133));
		mtab = '{1, 0, 255, 128};
		do_reset();
		// every op against boundary bytes, with carry both ways
		for (int k = 0; k <= 16; k++)
			for (int j = 0; j < 4; j++)
			begin
				preset(j * 5);
				issue(rss_op_e'(k), mtab[j], $urandom_range(0, 255), j * 2 + 1, 1'b0);
				issue(rss_op_e'(k), $urandom_range(0, 255), $urandom_range(0, 255),
				      $urandom_range(0, 7), 1'b1);
			end
		// back-to-back random stream
		for (int n = 0; n < 400; n++)
		begin
			if ($urandom_range(0, 9) == 0)
				preset($urandom_range(0, 15));
			else
				issue(rss_op_e'($urandom_range(0, 16)), $urandom_range(0, 255),
				      $urandom_range(0, 255), $urandom_range(0, 7), 1'($urandom));
		end
		do_reset();
		issue(OP_LOAD_WREG, 0, 5, 0, 1'b0);
		issue(OP_SUBTRACT, 3, 0, 0, 1'b0);
		final_report();
	end
endmodule : testbench
